/* common/smr_pkg.sv */
// package for the diagnostic converter monitor readback bank
// assumes an 8-bit register read port supplied by the device control-port logic
// ****************************************************************
// ****************************************************************
package smr_pkg;

  // ****************************************************************
  // source numbering and channel identifiers
  // ****************************************************************
  localparam int unsigned SMR_NSRC = 6;
  localparam logic [2:0] SMR_SRC_OUT1_NEG = 3'h0;
  localparam logic [2:0] SMR_SRC_OUT2_POS = 3'h1;
  localparam logic [2:0] SMR_SRC_OUT2_NEG = 3'h2;
  localparam logic [2:0] SMR_SRC_TEMP     = 3'h3;
  localparam logic [2:0] SMR_SRC_SUPPLY   = 3'h4;
  localparam logic [2:0] SMR_SRC_AUX      = 3'h5;

  localparam logic [3:0] SMR_ID_OUT1_NEG = 4'h7;
  localparam logic [3:0] SMR_ID_OUT2_POS = 4'h8;
  localparam logic [3:0] SMR_ID_OUT2_NEG = 4'h9;
  localparam logic [3:0] SMR_ID_TEMP     = 4'hA;
  localparam logic [3:0] SMR_ID_SUPPLY   = 4'hC;
  localparam logic [3:0] SMR_ID_AUX      = 4'hD;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] SMR_OUT1_NEG_MONITOR_LOW      = 8'h65;
  localparam logic [7:0] SMR_OUT2_POS_MONITOR_HIGH     = 8'h66;
  localparam logic [7:0] SMR_OUT2_POS_MONITOR_LOW      = 8'h67;
  localparam logic [7:0] SMR_OUT2_NEG_MONITOR_HIGH     = 8'h68;
  localparam logic [7:0] SMR_OUT2_NEG_MONITOR_LOW      = 8'h69;
  localparam logic [7:0] SMR_TEMPERATURE_MONITOR_HIGH  = 8'h6A;
  localparam logic [7:0] SMR_TEMPERATURE_MONITOR_LOW   = 8'h6B;
  localparam logic [7:0] SMR_SUPPLY_MONITOR_HIGH       = 8'h6E;
  localparam logic [7:0] SMR_SUPPLY_MONITOR_LOW        = 8'h6F;
  localparam logic [7:0] SMR_AUX_INPUT_MONITOR_HIGH    = 8'h70;
  localparam logic [7:0] SMR_AUX_INPUT_MONITOR_LOW     = 8'h71;

  // ****************************************************************
  // field layout and reset values
  // ****************************************************************
  localparam int unsigned SMR_RES_W      = 12;
  localparam int unsigned SMR_HIGH_LSB   = 4;
  localparam logic [11:0] SMR_RES_RESET  = 12'h000;
  localparam logic [7:0]  SMR_RD_UNMAPPED = 8'h00;

  // one conversion result from the converter
  typedef struct packed {
    logic        valid;
    logic [2:0]  src;
    logic [11:0] value;
  } smr_conv_s;

  // whole block state
  typedef struct packed {
    logic [SMR_NSRC-1:0][11:0] result;
    logic [7:0]                rd_data;
  } smr_state_s;

endpackage : smr_pkg

/* design/smr_readback.sv */
// readback bank holding the latest converter result per monitored source
// assumes conversion results and register reads arrive synchronous to clock_in
`timescale 1ns/1ps

module smr_readback (
  // clock and reset
  input  wire logic              clock_in,
  input  wire logic              resetn_in,
  // converter result stream
  input  wire smr_pkg::smr_conv_s conv_in,
  // control bits from the configuration registers
  input  wire logic              hold_readback_control_in,
  input  wire logic              supply_diag_enable_in,
  input  wire logic              aux_input_diag_enable_in,
  // register read port
  input  wire logic              rd_en_in,
  input  wire logic [7:0]        rd_addr_in,
  output logic      [7:0]        rd_data_out,
  // sources the sequencer should convert
  output logic      [5:0]        src_enable_out
);
  import smr_pkg::*;

  smr_state_s state;
  smr_state_s next_state;
  logic       accept;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // channel identifier per source, used by the low-register decode; the checks use literal ids
  function automatic logic [3:0] smr_id(input logic [2:0] src);
    unique case (src)
      SMR_SRC_OUT1_NEG: smr_id = SMR_ID_OUT1_NEG;
      SMR_SRC_OUT2_POS: smr_id = SMR_ID_OUT2_POS;
      SMR_SRC_OUT2_NEG: smr_id = SMR_ID_OUT2_NEG;
      SMR_SRC_TEMP:     smr_id = SMR_ID_TEMP;
      SMR_SRC_SUPPLY:   smr_id = SMR_ID_SUPPLY;
      SMR_SRC_AUX:      smr_id = SMR_ID_AUX;
      default:          smr_id = 4'h0;
    endcase
  endfunction : smr_id

  // high byte and low nibble plus id for one stored result
  function automatic logic [7:0] smr_high(input logic [11:0] v);
    smr_high = v[SMR_HIGH_LSB +: 8];
  endfunction : smr_high

  function automatic logic [7:0] smr_low(input logic [11:0] v, input logic [2:0] src);
    smr_low = {v[SMR_HIGH_LSB-1:0], smr_id(src)};
  endfunction : smr_low

  // ****************************************************************
  // source enables and result capture
  // ****************************************************************
  // supply and aux join the conversion cycle only when enabled
  always_comb begin
    src_enable_out = 6'h0F;
    src_enable_out[SMR_SRC_SUPPLY] = supply_diag_enable_in;
    src_enable_out[SMR_SRC_AUX]    = aux_input_diag_enable_in;
  end

  // a result from a disabled or unknown source is dropped; hold freezes all
  assign accept = conv_in.valid && !hold_readback_control_in
                  && (conv_in.src < 3'(SMR_NSRC))
                  && src_enable_out[conv_in.src];

  // ****************************************************************
  // next state: capture plus read mux
  // ****************************************************************
  // both halves come from one stored word, so a pair read while held never tears
  always_comb begin
    next_state = state;
    if (accept) begin
      next_state.result[conv_in.src] = conv_in.value;
    end
    unique case (rd_addr_in)
      SMR_OUT1_NEG_MONITOR_LOW:     next_state.rd_data = smr_low(state.result[0], 3'h0);
      SMR_OUT2_POS_MONITOR_HIGH:    next_state.rd_data = smr_high(state.result[1]);
      SMR_OUT2_POS_MONITOR_LOW:     next_state.rd_data = smr_low(state.result[1], 3'h1);
      SMR_OUT2_NEG_MONITOR_HIGH:    next_state.rd_data = smr_high(state.result[2]);
      SMR_OUT2_NEG_MONITOR_LOW:     next_state.rd_data = smr_low(state.result[2], 3'h2);
      SMR_TEMPERATURE_MONITOR_HIGH: next_state.rd_data = smr_high(state.result[3]);
      SMR_TEMPERATURE_MONITOR_LOW:  next_state.rd_data = smr_low(state.result[3], 3'h3);
      SMR_SUPPLY_MONITOR_HIGH:      next_state.rd_data = smr_high(state.result[4]);
      SMR_SUPPLY_MONITOR_LOW:       next_state.rd_data = smr_low(state.result[4], 3'h4);
      SMR_AUX_INPUT_MONITOR_HIGH:   next_state.rd_data = smr_high(state.result[5]);
      SMR_AUX_INPUT_MONITOR_LOW:    next_state.rd_data = smr_low(state.result[5], 3'h5);
      default:                      next_state.rd_data = SMR_RD_UNMAPPED;
    endcase
    if (!rd_en_in) begin
      next_state.rd_data = state.rd_data;
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  // results clear to zero; writes are never accepted, fields are read-only
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      // only constants here, so the reset path carries no data
      state.result  <= {SMR_NSRC{SMR_RES_RESET}};
      state.rd_data <= 8'h00;
    end else begin
      state <= next_state;
    end
  end

  // the port shows the flop only, so it holds between reads
  assign rd_data_out = state.rd_data;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  // all checks sleep during reset; read checks look one edge after the request

  AST_HIGH_BYTE: assert property (rd_en_in && rd_addr_in == SMR_TEMPERATURE_MONITOR_HIGH
    |=> rd_data_out == $past(state.result[3][11:4]))
    else $error("high byte read wrong");
  AST_LOW_NIBBLE: assert property (rd_en_in && rd_addr_in == SMR_SUPPLY_MONITOR_LOW
    |=> rd_data_out[7:4] == $past(state.result[4][3:0]))
    else $error("low nibble read wrong");
  AST_ID_OUT: assert property (rd_en_in && rd_addr_in == SMR_OUT2_POS_MONITOR_LOW
    |=> rd_data_out[3:0] == 4'h8)
    else $error("out2 pos id wrong");
  AST_ID_AUX: assert property (rd_en_in && rd_addr_in == SMR_AUX_INPUT_MONITOR_LOW
    |=> rd_data_out[3:0] == 4'hD)
    else $error("aux id wrong");
  AST_RESET_ZERO: assert property ($rose(resetn_in) |-> state.result == '0)
    else $error("results not zero after reset");
  AST_HOLD: assert property (hold_readback_control_in |=> $stable(state.result))
    else $error("result changed while held");
  AST_SUPPLY_EN: assert property (!supply_diag_enable_in |=> $stable(state.result[4]))
    else $error("disabled supply source updated");
  AST_PAIR: assert property (accept |=> state.result[$past(conv_in.src)]
    == $past(conv_in.value))
    else $error("pair not captured together");

  // high byte of the remaining sources
  AST_HI_O2P: assert property (rd_en_in && rd_addr_in == SMR_OUT2_POS_MONITOR_HIGH
    |=> rd_data_out == $past(state.result[SMR_SRC_OUT2_POS][11:4]))
    else $error("out2 pos high byte read wrong");
  AST_HI_O2N: assert property (rd_en_in && rd_addr_in == SMR_OUT2_NEG_MONITOR_HIGH
    |=> rd_data_out == $past(state.result[SMR_SRC_OUT2_NEG][11:4]))
    else $error("out2 neg high byte read wrong");
  AST_HI_SUP: assert property (rd_en_in && rd_addr_in == SMR_SUPPLY_MONITOR_HIGH
    |=> rd_data_out == $past(state.result[SMR_SRC_SUPPLY][11:4]))
    else $error("supply high byte read wrong");
  AST_HI_AUX: assert property (rd_en_in && rd_addr_in == SMR_AUX_INPUT_MONITOR_HIGH
    |=> rd_data_out == $past(state.result[SMR_SRC_AUX][11:4]))
    else $error("aux high byte read wrong");

  // low nibble of the remaining sources
  AST_LO_O1N: assert property (rd_en_in && rd_addr_in == SMR_OUT1_NEG_MONITOR_LOW
    |=> rd_data_out[7:4] == $past(state.result[SMR_SRC_OUT1_NEG][3:0]))
    else $error("out1 neg low nibble read wrong");
  AST_LO_O2P: assert property (rd_en_in && rd_addr_in == SMR_OUT2_POS_MONITOR_LOW
    |=> rd_data_out[7:4] == $past(state.result[SMR_SRC_OUT2_POS][3:0]))
    else $error("out2 pos low nibble read wrong");
  AST_LO_O2N: assert property (rd_en_in && rd_addr_in == SMR_OUT2_NEG_MONITOR_LOW
    |=> rd_data_out[7:4] == $past(state.result[SMR_SRC_OUT2_NEG][3:0]))
    else $error("out2 neg low nibble read wrong");
  AST_LO_TMP: assert property (rd_en_in && rd_addr_in == SMR_TEMPERATURE_MONITOR_LOW
    |=> rd_data_out[7:4] == $past(state.result[SMR_SRC_TEMP][3:0]))
    else $error("temperature low nibble read wrong");
  AST_LO_AUX: assert property (rd_en_in && rd_addr_in == SMR_AUX_INPUT_MONITOR_LOW
    |=> rd_data_out[7:4] == $past(state.result[SMR_SRC_AUX][3:0]))
    else $error("aux low nibble read wrong");

  // fixed identifiers of the remaining low registers
  AST_ID_O1N: assert property (rd_en_in && rd_addr_in == SMR_OUT1_NEG_MONITOR_LOW
    |=> rd_data_out[3:0] == 4'h7)
    else $error("out1 neg id wrong");
  AST_ID_O2N: assert property (rd_en_in && rd_addr_in == SMR_OUT2_NEG_MONITOR_LOW
    |=> rd_data_out[3:0] == 4'h9)
    else $error("out2 neg id wrong");
  AST_ID_TMP: assert property (rd_en_in && rd_addr_in == SMR_TEMPERATURE_MONITOR_LOW
    |=> rd_data_out[3:0] == 4'hA)
    else $error("temperature id wrong");
  AST_ID_SUP: assert property (rd_en_in && rd_addr_in == SMR_SUPPLY_MONITOR_LOW
    |=> rd_data_out[3:0] == 4'hC)
    else $error("supply id wrong");

  // reset value of the read port, a disabled aux source that must not update, and captures that must land when allowed
  AST_RESET_RD: assert property ($rose(resetn_in) |-> rd_data_out == 8'h00)
    else $error("read data not zero after reset");
  AST_AUX_EN: assert property (!aux_input_diag_enable_in
    |=> $stable(state.result[SMR_SRC_AUX]))
    else $error("disabled aux source updated");
  AST_TEMP_CAP: assert property (conv_in.valid && conv_in.src == SMR_SRC_TEMP
    && !hold_readback_control_in
    |=> state.result[SMR_SRC_TEMP] == $past(conv_in.value))
    else $error("temperature result not updated while free running");
  AST_SUP_CAP: assert property (conv_in.valid && conv_in.src == SMR_SRC_SUPPLY
    && supply_diag_enable_in && !hold_readback_control_in
    |=> state.result[SMR_SRC_SUPPLY] == $past(conv_in.value))
    else $error("enabled supply source not updated");
  AST_AUX_CAP: assert property (conv_in.valid && conv_in.src == SMR_SRC_AUX
    && aux_input_diag_enable_in && !hold_readback_control_in
    |=> state.result[SMR_SRC_AUX] == $past(conv_in.value))
    else $error("enabled aux source not updated");

  // ****************************************************************
  // cover properties
  // ****************************************************************
  // main traffic: capture then read, held conversions, paired reads, drops
  COV_CAPTURE: cover property (accept ##1 rd_en_in);
  COV_HOLD: cover property (hold_readback_control_in && conv_in.valid);
  COV_AUX_READ: cover property (rd_en_in && rd_addr_in == SMR_AUX_INPUT_MONITOR_LOW);
  COV_HELD_PAIR: cover property ((hold_readback_control_in && rd_en_in
    && rd_addr_in == SMR_TEMPERATURE_MONITOR_HIGH)
    ##1 (rd_en_in && rd_addr_in == SMR_TEMPERATURE_MONITOR_LOW));
  COV_SUPPLY_DROP: cover property (conv_in.valid && !supply_diag_enable_in
    && conv_in.src == SMR_SRC_SUPPLY);

endmodule : smr_readback

/* verification/smr_readback_tb.sv */
// self-checking bench for the monitor readback bank, no separate partner model
// assumes reads answer at the same edge that samples the request and the bank holds no writes
`timescale 1ns/1ps

module testbench;
  import smr_pkg::*;
  // ****************************************************************
  // stimulus and reference state
  // ****************************************************************
  logic        clock_in                 = 1'b0;
  logic        resetn_in                = 1'b0;
  smr_conv_s   conv_in                  = '0;
  logic        hold_readback_control_in = 1'b0;
  logic        supply_diag_enable_in    = 1'b0;
  logic        aux_input_diag_enable_in = 1'b0;
  logic        rd_en_in                 = 1'b0;
  logic [7:0]  rd_addr_in               = 8'h00;
  logic [7:0]  rd_data_out;
  logic [5:0]  src_enable_out;
  logic [7:0]  exp_q[$];
  logic [11:0] model[6];
  logic        rd_seen                  = 1'b0;
  logic [31:0] r;
  integer      error_cnt                = 0;
  integer      tests_run                = 0;
  integer      seed                     = 31;
  integer      k;
  localparam logic [7:0] lo_a[6] = '{8'h65, 8'h67, 8'h69, 8'h6B, 8'h6F, 8'h71};
  localparam logic [7:0] hi_a[6] = '{8'h64, 8'h66, 8'h68, 8'h6A, 8'h6E, 8'h70};
  localparam logic [3:0] ids[6]  = '{4'h7, 4'h8, 4'h9, 4'hA, 4'hC, 4'hD};

  always #5 clock_in = ~clock_in;

  smr_readback DUT (
    .clock_in(clock_in), .resetn_in(resetn_in), .conv_in(conv_in),
    .hold_readback_control_in(hold_readback_control_in),
    .supply_diag_enable_in(supply_diag_enable_in),
    .aux_input_diag_enable_in(aux_input_diag_enable_in),
    .rd_en_in(rd_en_in), .rd_addr_in(rd_addr_in), .rd_data_out(rd_data_out),
    .src_enable_out(src_enable_out)
  );

  // ****************************************************************
  // drivers and reference model
  // ****************************************************************
  // 0x64 belongs outside this bank, so source 0 has no high byte here
  function automatic logic [7:0] model_rd(input logic [7:0] a);
    model_rd = 8'h00;
    for (int i = 0; i < 6; i++) begin
      if (a == lo_a[i]) model_rd = {model[i][3:0], ids[i]};
      if (i > 0 && a == hi_a[i]) model_rd = model[i][11:4];
    end
  endfunction : model_rd

  // one cycle of traffic; reads see the store before this cycle's capture lands
  task automatic step(input logic cv, input logic [2:0] s, input logic [11:0] v,
                      input logic re, input logic [7:0] a);
    @(posedge clock_in);
    conv_in    <= '{cv, s, v};
    rd_en_in   <= re;
    rd_addr_in <= a;
    if (re) exp_q.push_back(model_rd(a));
    if (cv && !hold_readback_control_in && s < 3'h6 && !(s == 3'h4 && !supply_diag_enable_in)
        && !(s == 3'h5 && !aux_input_diag_enable_in)) model[s] = v;
  endtask : step

  // control change also idles the strobes so nothing is taken twice
  task automatic ctl(input logic h, input logic sp, input logic ax);
    @(posedge clock_in);
    conv_in.valid            <= 1'b0;
    rd_en_in                 <= 1'b0;
    hold_readback_control_in <= h;
    supply_diag_enable_in    <= sp;
    aux_input_diag_enable_in <= ax;
  endtask : ctl

  // sweep around the bank, unmapped places included, with no capture in flight
  task automatic sweep;
    for (int a = 8'h63; a < 8'h73; a++) step(1'b0, 3'h0, 12'h000, 1'b1, a[7:0]);
  endtask : sweep

  // idle the strobes and wait, bounded, for every outstanding read answer
  task automatic drain;
    step(1'b0, 3'h0, 12'h000, 1'b0, 8'h00);
    for (int i = 0; i < 5 && exp_q.size() != 0; i++) @(posedge clock_in);
    if (exp_q.size() != 0) begin
      error_cnt++;
      $display("[FAIL] %0t read answers missing", $time);
    end
  endtask : drain

  task automatic complete_run;
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  // ****************************************************************
  // output watcher: settled values are sampled on the falling edge
  // ****************************************************************
  always @(posedge clock_in) rd_seen <= rd_en_in && resetn_in;

  always @(negedge clock_in) begin
    if (resetn_in) begin
      tests_run++;
      if (src_enable_out !== {aux_input_diag_enable_in, supply_diag_enable_in, 4'hF}) begin
        error_cnt++;
        $display("[FAIL] %0t source enable mask wrong", $time);
      end
    end
    if (rd_seen) begin
      tests_run++;
      if (exp_q.size() == 0 || rd_data_out !== exp_q[0]) begin
        error_cnt++;
        $display("[FAIL] %0t read data mismatch", $time);
      end
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    for (k = 0; k < 6; k++) model[k] = 12'h000;
    repeat (12) @(posedge clock_in);
    resetn_in <= 1'b1;
    sweep();
    ctl(1'b0, 1'b1, 1'b1);
    step(1'b1, 3'h3, 12'hABC, 1'b0, 8'h00);
    step(1'b0, 3'h0, 12'h000, 1'b1, 8'h6A);
    step(1'b0, 3'h0, 12'h000, 1'b1, 8'h6B);
    // random mix: holds, disabled and out-of-range sources, back-to-back reads
    for (k = 0; k < 600; k++) begin
      r = $random(seed);
      if (r[2:0] == 3'h0) ctl(r[3], r[4], r[5]);
      r = $random(seed);
      step(r[0], r[3:1], r[15:4], r[16], 8'h63 + {4'h0, r[20:17]});
    end
    drain();
    // second reset in mid-run: every captured result must clear again
    resetn_in <= 1'b0;
    for (k = 0; k < 6; k++) model[k] = 12'h000;
    @(negedge clock_in);
    tests_run++;
    if (rd_data_out !== 8'h00) begin
      error_cnt++;
      $display("[FAIL] %0t read data not cleared by reset", $time);
    end
    repeat (3) @(posedge clock_in);
    resetn_in <= 1'b1;
    sweep();
    drain();
    complete_run();
  end
endmodule : testbench
